// *** include/hd_pkg.sv ***
// Purpose: Shared constants for the hopping decoder and its host link
// Assumes: 25 MHz system clock on both ends
// Notes: Long counts are mirrored as top-level parameters
package hd_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int NSLOT = 7;
  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_READ = 8'hf0;
  localparam logic [7:0] CMD_WRITE = 8'he1;
  localparam logic [7:0] CMD_ENROLL = 8'hd2;
  localparam logic [7:0] CMD_ERASE = 8'hc3;
  localparam logic [7:0] CMD_PROG = 8'hb4;
  // ==========================================================
  // Link timing
  localparam int NOTIFY_MS = 500;
  localparam int NOTIFY_CYC = NOTIFY_MS * (CLK_HZ / 1000);
  localparam int IDLE_US = 1000;
  localparam int IDLE_CYC = IDLE_US * (CLK_HZ / 1000000);
  localparam int COLL_US = 50;
  localparam int COLL_CYC = COLL_US * (CLK_HZ / 1000000);
  localparam int ENROLL_S = 30;
  localparam int ENROLL_CYC = ENROLL_S * CLK_HZ;
  localparam int HOST_ACK_US = 100;
  localparam int HOST_ACK_CYC = HOST_ACK_US * (CLK_HZ / 1000000);
  localparam int HALF_CYC = 8;
  // ==========================================================
  // Frame layout
  localparam int REP_BITS = 80;
  localparam int CMD_BITS = 24;
  localparam int DISC_BITS = 10;
  localparam int DISC_LSB = 16;
  localparam logic [15:0] WIN_SINGLE = 16'h0010;
  localparam logic [15:0] WIN_DOUBLE = 16'h4000;
endpackage

// *** include/hd_link_if.sv ***
// Purpose: Two-wire host link between decoder and host
// Assumes: Undriven data line reads low
// Notes: Host owns the clock; both ends may drive data
`timescale 1ns/1ps
`default_nettype none
interface hd_link_if;
  logic host_serial_clk;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic host_dat_o;
  logic host_dat_oe;
  logic host_serial_data;
  assign host_serial_data = dev_dat_oe ? dev_dat_o : (host_dat_oe ? host_dat_o : 1'b0);
  modport dev (input host_serial_clk, input host_serial_data, output dev_dat_o,
               output dev_dat_oe);
  modport host (output host_serial_clk, input host_serial_data, output host_dat_o,
                output host_dat_oe);
endinterface
`default_nettype wire

// *** logic/hd_device.sv ***
// Purpose: Decoder side: enrollment, validation and host link
// Assumes: Cipher primitive outside, start/done handshake
// Notes: Hop word: counter [15:0], discrimination [25:16]
// Summary of operation
// RL1 - Seven slots; empty first, else overwrite latest
// RL2 - Erase command empties every slot
// RL3 - Enroll command: confirm by data high
// RL4 - Two transmissions enroll; then status report
// RL5 - Abort on nonsequential codes or 30 s
// RL6 - Same key replaces existing slot in place
// RL7 - Integrity, derive, decrypt, discrimination before storing
// RL8 - Serial match, decrypt, 10-bit discrimination check
// RL9 - Failed slot moves search on; update counter
// RL10 - Counter within 16 ahead: accept
// RL11 - Double window: hold, accept next sequential
// RL12 - Reject beyond double window; window advances
// RL13 - Notify data high max 500 ms, clock acks
// RL14 - Report: start, flags, function, stop, slot, count, data
// RL15 - All link fields least significant bit first
// RL16 - Clock low over 1 ms ends report
// RL17 - Clock high requests command; data high, low, release
// RL18 - Host sends handshake, command, address, data bytes
// RL19 - Host sets bit at rise, device samples fall
// RL20 - Clock already high: drop report, serve command (code keeps report pending, notifies it after the command)
// RL21 - Rise under 50 us is command request
// RL22 - Command request answered within stated bound
// RL23 - Command byte codes F0 E1 D2 C3 B4
// RL24 - Cipher primitive with start and done
//
`timescale 1ns/1ps
`default_nettype none
module hd_device #(
  parameter int NOTIFY_CYC = hd_pkg::NOTIFY_CYC,
  parameter int IDLE_CYC = hd_pkg::IDLE_CYC,
  parameter int ENROLL_CYC = hd_pkg::ENROLL_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  hd_link_if.dev link,
  input wire logic rx_valid,
  input wire logic rx_intact,
  input wire logic rx_repeat,
  input wire logic weak_battery_flag,
  input wire logic [3:0] button_function_code,
  input wire logic [27:0] rx_serial,
  input wire logic [31:0] rx_hop,
  output logic cip_start,
  output logic cip_derive,
  output logic [63:0] cip_key,
  output logic [63:0] cip_in,
  input wire logic cip_done,
  input wire logic [63:0] cip_out,
  output logic enrolling,
  output logic [3:0] enrolled_count_bits
);
  localparam int N = hd_pkg::NSLOT;
  typedef enum logic [5:0] {
    V_IDLE = 6'b000001, V_SCAN = 6'b000010, V_KWAIT = 6'b000100,
    V_WAIT = 6'b001000, V_CHECK = 6'b010000, V_NEXT = 6'b100000
  } vst_e;
  typedef enum logic [7:0] {
    L_IDLE = 8'h01, L_NOTIFY = 8'h02, L_ACK = 8'h04, L_STREAM = 8'h08,
    L_CACK = 8'h10, L_CDROP = 8'h20, L_CRX = 8'h40, L_CONF = 8'h80
  } lst_e;
  vst_e vst_q;
  lst_e lst_q;
  logic [63:0] key_q [N];
  logic [27:0] ser_q [N];
  logic [15:0] cnt_q [N];
  logic [15:0] held_q [N];
  logic [N-1:0] held_v_q, used_q;
  logic [2:0] idx_q, last_q, sel_idx, match_idx, empty_idx;
  logic match_hit, empty_hit;
  logic [27:0] w_ser_q, lser_q;
  logic [31:0] w_hop_q, dec_q;
  logic [3:0] w_fc_q, nused;
  logic [1:0] w_flags_q;
  logic [15:0] lcnt_q, dcnt, diff;
  logic disc_ok, lstage_q, enroll_q, rep_pend_q, rep_take;
  logic [29:0] etimer_q;
  logic [79:0] rep_q, sh_q;
  logic [23:0] csh_q;
  logic [23:0] t_q;
  logic [6:0] n_q;
  logic s1, s2, s3, d1, d2, rise, fall, obit_q, dat_q, oe_q;
  logic cmd_enroll, cmd_erase;
  // ==========================================================
  // Slot lookup
  assign dcnt = dec_q[15:0];
  assign diff = dcnt - cnt_q[idx_q];
  assign disc_ok = dec_q[hd_pkg::DISC_LSB +: hd_pkg::DISC_BITS]
                   == w_ser_q[hd_pkg::DISC_BITS-1:0];  // [RL8]
  always_comb begin
    match_hit = 1'b0;
    match_idx = 3'h0;
    empty_hit = 1'b0;
    empty_idx = 3'h0;
    nused = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      nused = nused + 4'(used_q[i]);
      if (used_q[i] && key_q[i] == cip_key) begin
        match_hit = 1'b1;
        match_idx = 3'(i);
      end
      if (!used_q[i]) begin
        empty_hit = 1'b1;
        empty_idx = 3'(i);
      end
    end
    // Same key in place, else first empty, else latest enrolled
    sel_idx = match_hit ? match_idx : (empty_hit ? empty_idx : last_q);  // [RL1] [RL6]
  end
  assign enrolling = enroll_q;
  assign enrolled_count_bits = nused;
  // ==========================================================
  // Validation and enrollment sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vst_q <= V_IDLE;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      used_q <= '0;
      held_v_q <= '0;
      for (int i = 0; i < N; i++) begin
        key_q[i] <= 64'h0;
        ser_q[i] <= 28'h0;
        cnt_q[i] <= 16'h0;
        held_q[i] <= 16'h0;
      end
      w_ser_q <= 28'h0;
      w_hop_q <= 32'h0;
      w_fc_q <= 4'h0;
      w_flags_q <= 2'h0;
      dec_q <= 32'h0;
      lser_q <= 28'h0;
      lcnt_q <= 16'h0;
      lstage_q <= 1'b0;
      enroll_q <= 1'b0;
      etimer_q <= 30'h0;
      rep_pend_q <= 1'b0;
      rep_q <= 80'h0;
      cip_start <= 1'b0;
      cip_derive <= 1'b0;
      cip_key <= 64'h0;
      cip_in <= 64'h0;
    end else begin
      cip_start <= 1'b0;
      if (rep_take) begin
        rep_pend_q <= 1'b0;
      end
      etimer_q <= enroll_q ? etimer_q + 30'h1 : 30'h0;
      if (enroll_q && etimer_q >= 30'(ENROLL_CYC - 1)) begin
        enroll_q <= 1'b0;  // [RL5]
        lstage_q <= 1'b0;
      end
      if (cmd_enroll) begin
        enroll_q <= 1'b1;  // [RL3]
        lstage_q <= 1'b0;
      end
      if (cmd_erase) begin
        used_q <= '0;  // [RL2]
        held_v_q <= '0;
      end
      unique case (vst_q)
        V_IDLE: if (rx_valid && rx_intact) begin  // [RL7]
          w_ser_q <= rx_serial;
          w_hop_q <= rx_hop;
          w_fc_q <= button_function_code;
          w_flags_q <= {weak_battery_flag, rx_repeat};
          idx_q <= 3'h0;
          if (enroll_q) begin
            cip_start <= 1'b1;  // [RL24]
            cip_derive <= 1'b1;
            cip_in <= {36'h0, rx_serial};
            vst_q <= V_KWAIT;
          end else begin
            vst_q <= V_SCAN;
          end
        end
        V_SCAN: if (idx_q == 3'(N)) begin
          vst_q <= V_IDLE;  // [RL12]
        end else if (used_q[idx_q] && ser_q[idx_q] == w_ser_q) begin
          cip_start <= 1'b1;  // [RL8]
          cip_derive <= 1'b0;
          cip_key <= key_q[idx_q];
          cip_in <= {32'h0, w_hop_q};
          vst_q <= V_WAIT;
        end else begin
          idx_q <= idx_q + 3'h1;
        end
        V_KWAIT: if (cip_done) begin
          cip_key <= cip_out;  // [RL7]
          cip_start <= 1'b1;
          cip_derive <= 1'b0;
          cip_in <= {32'h0, w_hop_q};
          vst_q <= V_WAIT;
        end
        V_WAIT: if (cip_done) begin
          dec_q <= cip_out[31:0];  // [RL24]
          vst_q <= V_CHECK;
        end
        V_CHECK: begin
          vst_q <= V_IDLE;
          if (enroll_q) begin
            if (!disc_ok || (lstage_q && (w_ser_q != lser_q || dcnt != lcnt_q + 16'h1))) begin
              enroll_q <= 1'b0;  // [RL5]
              lstage_q <= 1'b0;
              rep_pend_q <= 1'b1;
              rep_q <= {w_fc_q, w_ser_q, dec_q, nused, 4'h0, 1'b1, 4'h0, 2'b00, 1'b0};
            end else if (!lstage_q) begin
              lstage_q <= 1'b1;  // [RL4]
              lser_q <= w_ser_q;
              lcnt_q <= dcnt;
            end else begin
              key_q[sel_idx] <= cip_key;  // [RL7]
              ser_q[sel_idx] <= w_ser_q;
              cnt_q[sel_idx] <= dcnt;
              used_q[sel_idx] <= 1'b1;
              held_v_q[sel_idx] <= 1'b0;
              last_q <= sel_idx;
              enroll_q <= 1'b0;
              lstage_q <= 1'b0;
              rep_pend_q <= 1'b1;  // [RL4]
              rep_q <= {w_fc_q, w_ser_q, dec_q, nused + 4'(~match_hit & empty_hit),
                        {1'b0, sel_idx}, 1'b1, 4'h0, !match_hit && !empty_hit, 1'b1, 1'b0};
            end
          end else if (!disc_ok) begin
            vst_q <= V_NEXT;  // [RL9]
          end else if (diff != 16'h0 && diff <= hd_pkg::WIN_SINGLE) begin
            cnt_q[idx_q] <= dcnt;  // [RL10]
            held_v_q[idx_q] <= 1'b0;
            rep_pend_q <= 1'b1;
            rep_q <= {w_fc_q, w_ser_q, dec_q, nused, {1'b0, idx_q}, 1'b1, w_fc_q,
                      w_flags_q, 1'b0};  // [RL14]
          end else if (diff != 16'h0 && diff < hd_pkg::WIN_DOUBLE) begin
            if (held_v_q[idx_q] && dcnt == held_q[idx_q] + 16'h1) begin
              cnt_q[idx_q] <= dcnt;  // [RL11]
              held_v_q[idx_q] <= 1'b0;
              rep_pend_q <= 1'b1;
              rep_q <= {w_fc_q, w_ser_q, dec_q, nused, {1'b0, idx_q}, 1'b1, w_fc_q,
                        w_flags_q, 1'b0};
            end else begin
              held_q[idx_q] <= dcnt;  // [RL11]
              held_v_q[idx_q] <= 1'b1;
            end
          end else begin
            vst_q <= V_NEXT;  // [RL12]
          end
        end
        V_NEXT: begin
          idx_q <= idx_q + 3'h1;  // [RL9]
          vst_q <= V_SCAN;
        end
      endcase
    end
  end
  // ==========================================================
  // Link pin synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      d1 <= 1'b0;
      d2 <= 1'b0;
    end else begin
      s1 <= link.host_serial_clk;
      s2 <= s1;
      s3 <= s2;
      d1 <= link.host_serial_data;
      d2 <= d1;
    end
  end
  assign rise = s2 && !s3;
  assign fall = !s2 && s3;
  assign rep_take = lst_q == L_NOTIFY && (rise || t_q >= 24'(NOTIFY_CYC - 1));
  assign cmd_enroll = lst_q == L_CRX && n_q == 7'(hd_pkg::CMD_BITS)
                      && csh_q[7:0] == hd_pkg::CMD_ENROLL;  // [RL23]
  assign cmd_erase = lst_q == L_CRX && n_q == 7'(hd_pkg::CMD_BITS)
                     && csh_q[7:0] == hd_pkg::CMD_ERASE;  // [RL23]
  // ==========================================================
  // Link sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lst_q <= L_IDLE;
      t_q <= 24'h0;
      n_q <= 7'h0;
      sh_q <= 80'h0;
      csh_q <= 24'h0;
      obit_q <= 1'b0;
    end else begin
      t_q <= (rise || fall) ? 24'h0 : t_q + 24'h1;
      unique case (lst_q)
        L_IDLE: if (s2) begin
          lst_q <= L_CACK;  // [RL20] [RL22]
        end else if (rep_pend_q) begin
          lst_q <= L_NOTIFY;  // [RL13]
          t_q <= 24'h0;
        end
        L_NOTIFY: if (rise) begin
          lst_q <= (t_q < 24'(hd_pkg::COLL_CYC)) ? L_CACK : L_ACK;  // [RL21]
          sh_q <= rep_q;
        end else if (t_q >= 24'(NOTIFY_CYC - 1)) begin
          lst_q <= L_IDLE;  // [RL13]
        end
        L_ACK: if (fall) begin
          lst_q <= L_STREAM;
          n_q <= 7'h0;
        end
        L_STREAM: begin
          if (rise) begin
            obit_q <= sh_q[0];  // [RL15]
            sh_q <= sh_q >> 1;
            n_q <= n_q + 7'h1;
          end
          if ((fall && n_q == 7'(hd_pkg::REP_BITS)) || (!s2 && t_q >= 24'(IDLE_CYC - 1))) begin
            lst_q <= L_IDLE;  // [RL16]
          end
        end
        L_CACK: if (fall) begin
          lst_q <= L_CDROP;  // [RL17]
        end
        L_CDROP: begin
          lst_q <= L_CRX;
          n_q <= 7'h0;
        end
        L_CRX: if (n_q == 7'(hd_pkg::CMD_BITS)) begin
          lst_q <= (cmd_enroll || cmd_erase) ? L_CONF : L_IDLE;
        end else if (fall) begin
          csh_q <= {d2, csh_q[23:1]};  // [RL19] [RL15]
          n_q <= n_q + 7'h1;
        end else if (t_q >= 24'(IDLE_CYC - 1)) begin
          lst_q <= L_IDLE;
        end
        L_CONF: if (fall) begin
          lst_q <= L_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // Data pin drive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dat_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= lst_q != L_IDLE && lst_q != L_CRX;  // [RL17]
      dat_q <= lst_q == L_NOTIFY || lst_q == L_CACK || lst_q == L_CONF
               || (lst_q == L_STREAM && obit_q);  // [RL3] [RL13]
    end
  end
  assign link.dev_dat_o = dat_q;
  assign link.dev_dat_oe = oe_q;
endmodule
`default_nettype wire

// *** logic/hd_host.sv ***
// Purpose: Host side: reads reports, sends commands over the link
// Assumes: Clock made here by divider of clk
// Notes: Command sequence ends with one activation pulse after the whole 24-bit command word
`timescale 1ns/1ps
`default_nettype none
module hd_host #(
  parameter int HALF = hd_pkg::HALF_CYC,
  parameter int ACK_WAIT = hd_pkg::HOST_ACK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  hd_link_if.host link,
  input wire logic cmd_go,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic busy,
  output logic rep_valid,
  output logic [79:0] rep_word
);
  typedef enum logic [7:0] {
    H_IDLE = 8'h01, H_WAITA = 8'h02, H_ACKH = 8'h04, H_RD = 8'h08,
    H_CREQ = 8'h10, H_CLOW = 8'h20, H_TX = 8'h40, H_ACT = 8'h80
  } hst_e;
  hst_e st_q;
  logic d1, d2, clk_q, do_q, oe_q, go_q, tick;
  logic [15:0] ph_q, tmr_q;
  logic [6:0] n_q;
  logic [23:0] cw_q;
  logic [79:0] sh_q;
  assign tick = ph_q == 16'(HALF - 1);
  assign busy = go_q || st_q != H_IDLE;
  assign link.host_serial_clk = clk_q;
  assign link.host_dat_o = do_q;
  assign link.host_dat_oe = oe_q;
  // ==========================================================
  // Data pin synchroniser and divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      d1 <= 1'b0;
      d2 <= 1'b0;
      ph_q <= 16'h0;
    end else begin
      d1 <= link.host_serial_data;
      d2 <= d1;
      ph_q <= tick ? 16'h0 : ph_q + 16'h1;
    end
  end
  // ==========================================================
  // Link sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= H_IDLE;
      clk_q <= 1'b0;
      do_q <= 1'b0;
      oe_q <= 1'b0;
      go_q <= 1'b0;
      tmr_q <= 16'h0;
      n_q <= 7'h0;
      cw_q <= 24'h0;
      sh_q <= 80'h0;
      rep_valid <= 1'b0;
      rep_word <= 80'h0;
    end else begin
      rep_valid <= 1'b0;
      if (cmd_go && !busy) begin
        go_q <= 1'b1;
        cw_q <= {cmd_data, cmd_addr, cmd_byte};  // [RL18]
      end
      if (st_q == H_ACT) oe_q <= 1'b0;
      unique case (st_q)
        H_IDLE: if (go_q) begin
          clk_q <= 1'b1;  // [RL17]
          st_q <= H_CREQ;
        end else if (d2) begin
          st_q <= H_WAITA;  // [RL13]
          tmr_q <= 16'h0;
        end
        H_WAITA: if (!d2) begin
          st_q <= H_IDLE;
        end else if (tmr_q == 16'(ACK_WAIT - 1)) begin
          clk_q <= 1'b1;  // [RL13] [RL21]
          st_q <= H_ACKH;
        end else begin
          tmr_q <= tmr_q + 16'h1;
        end
        H_ACKH: if (!d2) begin
          clk_q <= 1'b0;
          n_q <= 7'h0;
          st_q <= H_RD;
        end
        H_RD: if (tick) begin
          clk_q <= !clk_q;
          if (clk_q) begin
            sh_q <= {d2, sh_q[79:1]};  // [RL15] [RL16]
            n_q <= n_q + 7'h1;
            if (n_q == 7'(hd_pkg::REP_BITS - 1)) begin
              rep_valid <= 1'b1;
              rep_word <= {d2, sh_q[79:1]};
              st_q <= H_IDLE;
            end
          end
        end
        H_CREQ: if (d2) begin
          clk_q <= 1'b0;  // [RL17]
          tmr_q <= 16'h0;
          st_q <= H_CLOW;
        end
        H_CLOW: if (tmr_q == 16'(4 * HALF)) begin
          n_q <= 7'h0;
          st_q <= H_TX;
        end else begin
          tmr_q <= tmr_q + 16'h1;
        end
        H_TX: if (tick) begin
          clk_q <= !clk_q;
          if (!clk_q) begin
            oe_q <= 1'b1;  // [RL19]
            do_q <= cw_q[0];
          end else begin
            cw_q <= cw_q >> 1;  // [RL15]
            n_q <= n_q + 7'h1;
            if (n_q == 7'(hd_pkg::CMD_BITS - 1)) begin
              st_q <= H_ACT;
            end
          end
        end
        H_ACT: if (tick) begin
          if (clk_q) begin
            clk_q <= 1'b0;
            go_q <= 1'b0;
            st_q <= H_IDLE;
          end else if (n_q == 7'(hd_pkg::CMD_BITS)) begin
            n_q <= 7'h0;
            clk_q <= 1'b1;  // [RL2] [RL23]
          end else begin
            go_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/hd_link_checker.sv ***
// Purpose: Wire checks on the decoder host link
// Assumes: One clock domain, rstn async active low
// Notes: Sees only the interface signals
`timescale 1ns/1ps
`default_nettype none
module hd_link_checker #(
  parameter int NOTIFY = 3000,
  parameter int IDLE = 200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_serial_clk,
  input wire logic dev_dat_o,
  input wire logic dev_dat_oe,
  input wire logic host_dat_o,
  input wire logic host_dat_oe,
  input wire logic host_serial_data
);
  int low_n, hi_n, dl_n, bit_n;
  logic ack_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Run lengths of clock low, notify high, driven low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_n <= 0;
      hi_n <= 0;
      dl_n <= 0;
    end else begin
      low_n <= host_serial_clk ? 0 : low_n + 1;
      hi_n <= (!host_serial_clk && dev_dat_oe && dev_dat_o) ? hi_n + 1 : 0;
      dl_n <= (!host_serial_clk && dev_dat_oe && !dev_dat_o) ? dl_n + 1 : 0;
    end
  end
  // ==========================================================
  // Command request open, device-driven falls per session
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      bit_n <= 0;
    end else begin
      if ($rose(host_serial_clk) && low_n > IDLE + 8 && !dev_dat_oe)
        ack_q <= 1'b1;
      else if ($fell(host_serial_clk))
        ack_q <= 1'b0;
      if (low_n > IDLE + 8)
        bit_n <= 0;
      else if ($fell(host_serial_clk) && dev_dat_oe)
        bit_n <= bit_n + 1;
    end
  end
  sequence cmd_req_s;
    $rose(host_serial_clk) && low_n > IDLE + 8 && !dev_dat_oe;
  endsequence
  sequence drop_release_s;
    (dev_dat_oe && !dev_dat_o) ##[1:2] !dev_dat_oe;
  endsequence
  no_contention_a: assert property (!(dev_dat_oe && host_dat_oe))
    else $error("both ends drive data");
  notify_max_a: assert property (hi_n <= NOTIFY + 8)
    else $error("notify held too long");
  report_ack_a: assert property (
    $rose(host_serial_clk) && hi_n > hd_pkg::COLL_CYC + 50
    |-> ##[1:8] (dev_dat_oe && !dev_dat_o)) else $error("report ack missing");
  cmd_ack_a: assert property (cmd_req_s |-> ##[1:10] (dev_dat_oe && dev_dat_o))
    else $error("command request not answered");
  ack_release_a: assert property ($fell(host_serial_clk) && ack_q |-> ##[1:6] drop_release_s)
    else $error("data not dropped and released");
  stream_end_a: assert property (dl_n <= IDLE + 8)
    else $error("stream outlived idle clock");
  data_hold_a: assert property ($fell(host_serial_clk) && dev_dat_oe |-> $stable(dev_dat_o))
    else $error("data moved at clock fall");
  bit_count_a: assert property (bit_n <= 81)
    else $error("too many bits driven");
endmodule
`default_nettype wire

// *** bench/hopping_decoder_learn_and_host_link_tb_top.sv ***
// Purpose: Bench joining decoder and host over the link
// Assumes: Identity cipher model, done two cycles after start
// Notes: Long counts shortened through parameters
`timescale 1ns/1ps
`default_nettype none
module hopping_decoder_learn_and_host_link_tb_top;
  localparam int NOTIFY = 3000;
  localparam int IDLE = 200;
  localparam logic [7:0] NOP_CMDS [3] = '{hd_pkg::CMD_READ, hd_pkg::CMD_WRITE, hd_pkg::CMD_PROG};
  logic clk = 1'b0;
  logic rstn, rx_valid, rx_intact, rx_repeat, weak_battery_flag, cmd_go, cip_done;
  logic [3:0] button_function_code, enrolled_count_bits;
  logic [27:0] rx_serial;
  logic [31:0] rx_hop;
  logic [7:0] cmd_byte, cmd_addr, cmd_data;
  logic cip_start, cip_derive, enrolling, busy, rep_valid;
  logic [63:0] cip_key, cip_in, cip_out;
  logic [79:0] rep_word, e;
  logic [79:0] cap = 80'h0;
  logic [1:0] cip_q = 2'h0;
  logic [15:0] rnd, c;
  logic [27:0] ser [8];
  logic [15:0] sc [8];
  int failures = 0;
  int comparisons = 0;
  bit g;
  hd_link_if link();
  hd_device #(.NOTIFY_CYC(NOTIFY), .IDLE_CYC(IDLE), .ENROLL_CYC(5000)) u_hd_device (
    .clk(clk), .rstn(rstn), .link(link), .rx_valid(rx_valid), .rx_intact(rx_intact),
    .rx_repeat(rx_repeat), .weak_battery_flag(weak_battery_flag),
    .button_function_code(button_function_code), .rx_serial(rx_serial), .rx_hop(rx_hop),
    .cip_start(cip_start), .cip_derive(cip_derive), .cip_key(cip_key), .cip_in(cip_in),
    .cip_done(cip_done), .cip_out(cip_out), .enrolling(enrolling),
    .enrolled_count_bits(enrolled_count_bits));
  hd_host u_hd_host (.clk(clk), .rstn(rstn), .link(link), .cmd_go(cmd_go),
    .cmd_byte(cmd_byte), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy),
    .rep_valid(rep_valid), .rep_word(rep_word));
  hd_link_checker #(.NOTIFY(NOTIFY), .IDLE(IDLE)) u_hd_link_checker (.clk(clk),
    .rstn(rstn), .host_serial_clk(link.host_serial_clk), .dev_dat_o(link.dev_dat_o),
    .dev_dat_oe(link.dev_dat_oe), .host_dat_o(link.host_dat_o),
    .host_dat_oe(link.host_dat_oe), .host_serial_data(link.host_serial_data));
  // ==========================================================
  // Clock, cipher stand-in, wire capture
  always #20 clk = ~clk;
  always @(posedge clk) cip_q <= {cip_q[0], cip_start};
  assign cip_done = cip_q[1];
  assign cip_out = cip_in;
  always @(negedge link.host_serial_clk) cap <= {link.host_serial_data, cap[79:1]};
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [79:0] rep_exp();
    return {button_function_code, rx_serial, rx_hop, 4'h7, 4'h0, 1'b1, button_function_code,
      weak_battery_flag, rx_repeat, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [79:0] x, input logic [79:0] y);
    comparisons++;
    if (y !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic send_cmd(input logic [7:0] b);
    int n;
    rnd = lfsr(rnd);
    repeat (240) @(posedge clk);
    cmd_go <= 1'b1;
    cmd_byte <= b;
    cmd_addr <= rnd[7:0];
    cmd_data <= rnd[15:8];
    @(posedge clk);
    cmd_go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 4000);
    repeat (4) @(posedge clk);
  endtask
  task automatic send_rx(input logic [27:0] s, input logic [15:0] k, input logic [9:0] d);
    rnd = lfsr(rnd);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_serial <= s;
    rx_hop <= {6'h00, d, k};
    rx_repeat <= rnd[0];
    weak_battery_flag <= rnd[1];
    button_function_code <= rnd[5:2];
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (100) @(posedge clk);
  endtask
  task automatic wait_rep(output bit f);
    f = 1'b0;
    for (int i = 0; i < 6000 && !f; i++) begin
      @(negedge clk);
      f = (rep_valid === 1'b1);
    end
  endtask
  task automatic no_rep(input string nm);
    bit f;
    f = 1'b0;
    repeat (400) begin
      @(negedge clk);
      if (link.host_serial_data === 1'b1) f = 1'b1;
    end
    chk(nm, 80'h0, {79'h0, f});
  endtask
  task automatic enroll(input logic [27:0] s, input logic [15:0] k, input logic [15:0] k2);
    bit f;
    send_cmd(hd_pkg::CMD_ENROLL);
    chk("enrolling", 80'h1, {79'h0, enrolling});
    send_rx(s, k, s[9:0]);
    send_rx(s, k2, s[9:0]);
    wait_rep(f);
    chk("enroll status seen", 80'h1, {79'h0, f});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rstn, rx_valid, rx_repeat, weak_battery_flag, cmd_go} = 5'h00;
    rx_intact = 1'b1;
    {button_function_code, rx_serial, rx_hop} = 64'h0;
    {cmd_byte, cmd_addr, cmd_data} = 24'h0;
    rnd = 16'h17b2;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (NOP_CMDS[i]) begin
      send_cmd(NOP_CMDS[i]);
      chk("enrolling idle", 80'h0, {79'h0, enrolling});
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ser[i] = {rnd[11:0], rnd};
      c = rnd;
      sc[i] = c + 16'h1;
      enroll(ser[i], c, sc[i]);
      e = {64'h0, (i < 7) ? 4'(i + 1) : 4'h7, (i < 7) ? 4'(i) : 4'h6, 5'h10, i == 7, 2'b10};
      chk("enroll status", e, {64'h0, rep_word[15:0]});
    end
    c = sc[1] + 16'h20;
    enroll(ser[1], c, c + 16'h1);
    chk("same key status", {64'h0, 16'h7182}, {64'h0, rep_word[15:0]});
    rnd = lfsr(rnd);
    c = sc[0] + {12'h0, rnd[3:0] | 4'h1};
    send_rx(ser[0], c, ser[0][9:0]);
    wait_rep(g);
    chk("report seen", 80'h1, {79'h0, g});
    chk("report word", rep_exp(), rep_word);
    chk("line bits", rep_exp(), cap);
    send_rx(ser[0], c, ser[0][9:0]);
    no_rep("replayed code");
    send_rx(ser[0], c + 16'h1, ~ser[0][9:0]);
    no_rep("bad discrimination");
    send_rx(ser[0], c + 16'h64, ser[0][9:0]);
    no_rep("held counter");
    send_rx(ser[0], c + 16'h65, ser[0][9:0]);
    wait_rep(g);
    chk("resync seen", 80'h1, {79'h0, g});
    chk("resync word", rep_exp(), rep_word);
    send_rx(ser[0], c + 16'h8065, ser[0][9:0]);
    no_rep("blocked counter");
    rnd = lfsr(rnd);
    enroll({rnd[11:0], rnd}, rnd, rnd + 16'h5);
    chk("nonsequential result", 80'h0, {79'h0, rep_word[1]});
    chk("count kept", 80'h7, {76'h0, enrolled_count_bits});
    send_cmd(hd_pkg::CMD_ERASE);
    chk("count after erase", 80'h0, {76'h0, enrolled_count_bits});
    send_rx(ser[0], c + 16'h66, ser[0][9:0]);
    no_rep("erased slot");
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
